// ==== eep_pkg.sv ====
// Shared constants and types for the serial EEPROM device and its bus master
package eep_pkg;
  // Byte and address layout
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 10;
  localparam int MEM_BYTES = 1024;
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [9:0] ADDR_RST = 10'h000;
  localparam logic [7:0] LEN_ONE = 8'h01;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WR_TIME_NS = 5000000;
  localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Phases of one symbol on the link
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  // Device frame states
  typedef enum logic [4:0] {
    DS_IDLE    = 5'h01,
    DS_DEVADR  = 5'h02,
    DS_WORDADR = 5'h04,
    DS_WRDATA  = 5'h08,
    DS_RDDATA  = 5'h10
  } dev_state_type;
  // Host commands
  typedef enum logic [1:0] {
    CMD_WRITE     = 2'h0,
    CMD_RAND_READ = 2'h1,
    CMD_CUR_READ  = 2'h2
  } cmd_type;
  // Host sequence stages
  typedef enum logic [11:0] {
    HS_IDLE   = 12'h001,
    HS_START  = 12'h002,
    HS_DEVW   = 12'h004,
    HS_WADR   = 12'h008,
    HS_WDAT   = 12'h010,
    HS_RSTART = 12'h020,
    HS_DEVR   = 12'h040,
    HS_RDAT   = 12'h080,
    HS_STOP   = 12'h100,
    HS_PSTART = 12'h200,
    HS_PDEV   = 12'h400,
    HS_PSTOP  = 12'h800
  } host_stage_type;
endpackage

// ==== eeprom_link_if.sv ====
// Two-wire link between the bus master and the EEPROM device
`timescale 1ns/100ps
`default_nettype none
interface eeprom_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND of both open-drain drivers, pulled up when released
  assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (output scl, output host_sda_out, output host_sda_oe, input sda);
endinterface
`default_nettype wire

// ==== eeprom_dev.sv ====
// Serial EEPROM device end: frame decoder, address counter, array, write timer
//
// Contract
// - No acknowledge to address while writing internally
// - Master polls with write-direction address byte
// - Master waits for polled acknowledge first
// - Write protect high inhibits all array programming
// - Three read kinds, direction bit one
// - Counter holds last accessed address plus one
// - Counter keeps value between bus operations
// - Read wraps counter from top to zero
// - Write wraps within the current page
// - Read address acked, shift byte MSB first
// - Master ends single read with no-ack, stop
// - Dummy write loads word address into counter
// - Master repeats start without stop
// - Read after repeated start uses loaded address
// - Master acks each byte to continue
// - Master ack increments counter, next byte out
// - Sequential read wraps to zero seamlessly
// - No-ack then stop ends read, release
// - Write time runs from the ending stop
// - Address byte: 1010, select, page, direction
// - Drive line low on ninth clock
// - Page bits are word address MSBs
// - Page write increments low four bits only
`timescale 1ns/100ps
`default_nettype none
module eeprom_dev #(
  parameter int WR_CYCLES = eep_pkg::WR_CYCLES
) (
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  arst_n_in,
  // Two-wire link
  eeprom_link_if.dev link,
  // Strap and protect pins
  input  wire logic  chip_select_address_bit_in,
  input  wire logic  write_protect_in,
  // Status
  output logic       busy_out
);
  localparam int CNT_W = $clog2(WR_CYCLES + 1);

  logic [1:0]             scl_sync_r;
  logic [1:0]             sda_sync_r;
  logic [1:0]             wp_sync_r;
  logic [1:0]             cs_sync_r;
  logic                   scl_d_r;
  logic                   sda_d_r;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  logic                   last_bit;
  logic                   frame_end;
  logic                   dev_match;
  logic                   wr_en;
  eep_pkg::dev_state_type state_r;
  logic [3:0]             bit_cnt_r;
  logic [7:0]             shift_r;
  logic [7:0]             tx_r;
  logic [9:0]             addr_r;
  logic [1:0]             page_r;
  logic                   sda_oe_r;
  logic                   pend_wr_r;
  logic                   busy_r;
  logic [CNT_W-1:0]       wr_cnt_r;
  logic [7:0]             mem [0:eep_pkg::MEM_BYTES-1];

  // Two-stage synchronisers; the bus clock is sampled, not used as a clock
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      wp_sync_r  <= 2'h3;
      cs_sync_r  <= 2'h0;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], link.scl};
      sda_sync_r <= {sda_sync_r[0], link.sda};
      wp_sync_r  <= {wp_sync_r[0], write_protect_in};
      cs_sync_r  <= {cs_sync_r[0], chip_select_address_bit_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  // Edge and condition detection on the synchronised lines
  assign scl_rise  = scl_sync_r[1] & ~scl_d_r;
  assign scl_fall  = ~scl_sync_r[1] & scl_d_r;
  assign start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
  assign stop_det  = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
  assign last_bit  = (bit_cnt_r == eep_pkg::BIT_ACK);
  assign frame_end = scl_rise & last_bit;

  // Address byte compare, refused while the write timer runs
  assign dev_match = (shift_r[7:4] == eep_pkg::DEV_CODE)
                   && (shift_r[3] == cs_sync_r[1])
                   && !busy_r;

  // Protected writes are acknowledged but never reach the array
  assign wr_en = frame_end && (state_r == eep_pkg::DS_WRDATA) && !wp_sync_r[1];

  // Bit counter and receive shifter; sampled on rising clock
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bit_cnt_r <= eep_pkg::BIT_FIRST;
      shift_r   <= 8'h00;
    end
    else if (start_det || stop_det)
    begin
      bit_cnt_r <= eep_pkg::BIT_FIRST;
    end
    else if (scl_rise)
    begin
      bit_cnt_r <= last_bit ? eep_pkg::BIT_FIRST : 4'(bit_cnt_r + 4'h1);
      if (!last_bit)
      begin
        shift_r <= {shift_r[6:0], sda_sync_r[1]};
      end
    end
  end

  // Frame state; start always restarts decoding, even when busy
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_r <= eep_pkg::DS_IDLE;
    end
    else if (start_det)
    begin
      state_r <= eep_pkg::DS_DEVADR;
    end
    else if (stop_det)
    begin
      state_r <= eep_pkg::DS_IDLE;
    end
    else if (frame_end)
    begin
      case (state_r)
        eep_pkg::DS_DEVADR:
        begin
          if (!sda_oe_r)
            state_r <= eep_pkg::DS_IDLE;
          else if (shift_r[0])
            state_r <= eep_pkg::DS_RDDATA;
          else
            state_r <= eep_pkg::DS_WORDADR;
        end
        eep_pkg::DS_WORDADR:
        begin
          state_r <= eep_pkg::DS_WRDATA;
        end
        eep_pkg::DS_WRDATA:
        begin
          state_r <= eep_pkg::DS_WRDATA;
        end
        eep_pkg::DS_RDDATA:
        begin
          // Master no-ack ends the read and frees the line
          state_r <= sda_sync_r[1] ? eep_pkg::DS_IDLE : eep_pkg::DS_RDDATA;
        end
        default:
        begin
          state_r <= eep_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // Line driver, changed on falling clock so data is stable while high, and released on any start or stop
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sda_oe_r <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      sda_oe_r <= 1'b0;
    end
    else if (scl_fall)
    begin
      case (state_r)
        eep_pkg::DS_DEVADR:
        begin
          sda_oe_r <= last_bit && dev_match;
        end
        eep_pkg::DS_WORDADR,
        eep_pkg::DS_WRDATA:
        begin
          sda_oe_r <= last_bit;
        end
        eep_pkg::DS_RDDATA:
        begin
          // Ninth slot released so the master can answer
          sda_oe_r <= !last_bit && !tx_r[7];
        end
        default:
        begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Word address counter and transmit byte; counter survives stop and start
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      addr_r <= eep_pkg::ADDR_RST;
      page_r <= 2'h0;
      tx_r   <= 8'h00;
    end
    else if (frame_end)
    begin
      case (state_r)
        eep_pkg::DS_DEVADR:
        begin
          if (sda_oe_r)
          begin
            page_r <= shift_r[2:1];
            if (shift_r[0])
            begin
              tx_r   <= mem[addr_r];
              addr_r <= addr_r + 10'h001;
            end
          end
        end
        eep_pkg::DS_WORDADR:
        begin
          addr_r <= {page_r, shift_r};
        end
        eep_pkg::DS_WRDATA:
        begin
          // Page row held, only the low nibble moves
          addr_r <= {addr_r[9:4], 4'(addr_r[3:0] + 4'h1)};
        end
        eep_pkg::DS_RDDATA:
        begin
          if (!sda_sync_r[1])
          begin
            tx_r   <= mem[addr_r];
            addr_r <= addr_r + 10'h001;
          end
        end
        default:
        begin
          addr_r <= addr_r;
        end
      endcase
    end
    else if (scl_fall && (state_r == eep_pkg::DS_RDDATA) && !last_bit)
    begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // Array; no reset, contents are the stored data
  always_ff @(posedge clk_in)
  begin
    if (wr_en)
    begin
      mem[addr_r] <= shift_r;
    end
  end

  // Write timer started by the stop that ends a write
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pend_wr_r <= 1'b0;
      busy_r    <= 1'b0;
      wr_cnt_r  <= '0;
    end
    else
    begin
      pend_wr_r <= wr_en || (pend_wr_r && !stop_det);
      if (stop_det && pend_wr_r)
      begin
        busy_r   <= 1'b1;
        wr_cnt_r <= CNT_W'(WR_CYCLES - 1);
      end
      else if (busy_r)
      begin
        busy_r   <= (wr_cnt_r != '0);
        wr_cnt_r <= wr_cnt_r - 1'b1;
      end
    end
  end

  // Open-drain: only ever pulls low
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe  = sda_oe_r;
  assign busy_out         = busy_r;
endmodule
`default_nettype wire

// ==== eeprom_host.sv ====
// Bus master end: command sequencer, clock divider and read buffer
`timescale 1ns/100ps
`default_nettype none
module eeprom_rd_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] buf_r [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    cnt_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_r != CW'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = buf_r[rd_ptr_r];

  // Storage, written only on accepted pushes
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      buf_r[wr_ptr_r] <= in_data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_r + 1'b1);
      if (pop)
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_r + 1'b1);
      cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
    end
  end
endmodule

module eeprom_host (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Two-wire link
  eeprom_link_if.host           link,
  // Command request
  input  wire logic             cmd_valid_in,
  output logic                  cmd_ready_out,
  input  wire eep_pkg::cmd_type cmd_kind_in,
  input  wire logic             cmd_cs_in,
  input  wire logic [9:0]       cmd_addr_in,
  input  wire logic [7:0]       cmd_data_in,
  input  wire logic [7:0]       cmd_len_in,
  // Read data stream
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [7:0]            rd_data_out,
  // Completion
  output logic                  done_out,
  output logic                  nack_out
);
  localparam int TW = $clog2(eep_pkg::QTR_CYCLES);

  eep_pkg::host_stage_type stage_r;
  eep_pkg::cmd_type        kind_r;
  logic [1:0]              sda_sync_r;
  logic [TW-1:0]           tick_r;
  logic [1:0]              phase_r;
  logic [3:0]              bit_cnt_r;
  logic                    cs_r;
  logic [9:0]              addr_r;
  logic [7:0]              data_r;
  logic [7:0]              len_r;
  logic [7:0]              rx_r;
  logic                    ack_r;
  logic                    err_r;
  logic                    done_r;
  logic                    nack_r;
  logic                    scl_r;
  logic                    oe_r;
  logic                    is_idle;
  logic                    is_start;
  logic                    is_stop;
  logic                    is_rx;
  logic                    last_sym;
  logic                    stall;
  logic                    tick_end;
  logic                    sym_end;
  logic                    fifo_ready;
  logic                    fifo_push;
  logic                    sda_val;
  logic                    scl_val;
  logic [7:0]              tx_byte;
  logic [7:0]              tx_bits;

  assign is_idle  = (stage_r == eep_pkg::HS_IDLE);
  assign is_start = (stage_r == eep_pkg::HS_START) || (stage_r == eep_pkg::HS_RSTART)
                  || (stage_r == eep_pkg::HS_PSTART);
  assign is_stop  = (stage_r == eep_pkg::HS_STOP) || (stage_r == eep_pkg::HS_PSTOP);
  assign is_rx    = (stage_r == eep_pkg::HS_RDAT);
  assign last_sym = (is_start || is_stop) || (bit_cnt_r == eep_pkg::BIT_ACK);
  // A byte is not begun until the buffer can take it
  assign stall    = is_rx && (bit_cnt_r == eep_pkg::BIT_FIRST)
                  && (phase_r == eep_pkg::PH_FIRST) && !fifo_ready;
  assign tick_end = !is_idle && !stall && (tick_r == TW'(eep_pkg::QTR_CYCLES - 1));
  assign sym_end  = tick_end && (phase_r == eep_pkg::PH_LAST);
  assign fifo_push = sym_end && is_rx && last_sym;
  assign tx_bits  = tx_byte << bit_cnt_r[2:0];

  // Byte sent in each stage
  always_comb
  begin
    case (stage_r)
      eep_pkg::HS_DEVR: tx_byte = {eep_pkg::DEV_CODE, cs_r, addr_r[9:8], 1'b1};
      eep_pkg::HS_WADR: tx_byte = addr_r[7:0];
      eep_pkg::HS_WDAT: tx_byte = data_r;
      default:          tx_byte = {eep_pkg::DEV_CODE, cs_r, addr_r[9:8], 1'b0};
    endcase
  end

  // Line levels per phase; clock high in the middle two quarters, in the last three for a stop
  always_comb
  begin
    sda_val = 1'b1;
    scl_val = 1'b1;
    if (is_start)
    begin
      sda_val = !phase_r[1];
      scl_val = phase_r[0] ^ phase_r[1];
    end
    else if (is_stop)
    begin
      sda_val = phase_r[1];
      scl_val = (phase_r != eep_pkg::PH_FIRST);
    end
    else if (is_rx)
    begin
      sda_val = last_sym ? (len_r <= eep_pkg::LEN_ONE) : 1'b1;
      scl_val = phase_r[0] ^ phase_r[1];
    end
    else if (!is_idle)
    begin
      sda_val = last_sym ? 1'b1 : tx_bits[7];
      scl_val = phase_r[0] ^ phase_r[1];
    end
  end

  // Registered pins and synchronised data line
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      scl_r      <= 1'b1;
      oe_r       <= 1'b0;
      sda_sync_r <= 2'h3;
    end
    else
    begin
      scl_r      <= scl_val;
      oe_r       <= !sda_val;
      sda_sync_r <= {sda_sync_r[0], link.sda};
    end
  end

  // Quarter-period divider, phase and bit counters
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tick_r    <= '0;
      phase_r   <= eep_pkg::PH_FIRST;
      bit_cnt_r <= eep_pkg::BIT_FIRST;
    end
    else
    begin
      tick_r <= (is_idle || stall || tick_end) ? '0 : TW'(tick_r + 1'b1);
      if (is_idle)
        phase_r <= eep_pkg::PH_FIRST;
      else if (tick_end)
        phase_r <= 2'(phase_r + 2'h1);
      if (is_idle)
        bit_cnt_r <= eep_pkg::BIT_FIRST;
      else if (sym_end)
        bit_cnt_r <= last_sym ? eep_pkg::BIT_FIRST : 4'(bit_cnt_r + 4'h1);
    end
  end

  // Sampling at the end of the high clock phase
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ack_r <= 1'b0;
      rx_r  <= 8'h00;
    end
    else if (tick_end && (phase_r == eep_pkg::PH_SAMPLE))
    begin
      if (is_rx && !last_sym)
        rx_r <= {rx_r[6:0], sda_sync_r[1]};
      else if (!is_rx && !is_start && !is_stop && last_sym)
        ack_r <= !sda_sync_r[1];
    end
  end

  // Command capture and remaining read length
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      kind_r <= eep_pkg::CMD_WRITE;
      cs_r   <= 1'b0;
      addr_r <= eep_pkg::ADDR_RST;
      data_r <= 8'h00;
      len_r  <= eep_pkg::LEN_ONE;
    end
    else if (is_idle && cmd_valid_in)
    begin
      kind_r <= cmd_kind_in;
      cs_r   <= cmd_cs_in;
      addr_r <= cmd_addr_in;
      data_r <= cmd_data_in;
      len_r  <= cmd_len_in;
    end
    else if (fifo_push)
    begin
      len_r <= 8'(len_r - 8'h01);
    end
  end

  // Sequencer; an error-free write is followed by polling until acknowledged
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stage_r <= eep_pkg::HS_IDLE;
      err_r   <= 1'b0;
      done_r  <= 1'b0;
      nack_r  <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (is_idle && cmd_valid_in)
      begin
        stage_r <= eep_pkg::HS_START;
        err_r   <= 1'b0;
      end
      else if (sym_end && last_sym)
      begin
        case (stage_r)
          eep_pkg::HS_START:
            stage_r <= (kind_r == eep_pkg::CMD_CUR_READ) ? eep_pkg::HS_DEVR : eep_pkg::HS_DEVW;
          eep_pkg::HS_DEVW:
          begin
            stage_r <= ack_r ? eep_pkg::HS_WADR : eep_pkg::HS_STOP;
            err_r   <= !ack_r;
          end
          eep_pkg::HS_WADR:
          begin
            if (!ack_r)
              stage_r <= eep_pkg::HS_STOP;
            else if (kind_r == eep_pkg::CMD_WRITE)
              stage_r <= eep_pkg::HS_WDAT;
            else
              stage_r <= eep_pkg::HS_RSTART;
            err_r <= !ack_r;
          end
          eep_pkg::HS_WDAT:
          begin
            stage_r <= eep_pkg::HS_STOP;
            err_r   <= !ack_r;
          end
          eep_pkg::HS_RSTART:
            stage_r <= eep_pkg::HS_DEVR;
          eep_pkg::HS_DEVR:
          begin
            stage_r <= ack_r ? eep_pkg::HS_RDAT : eep_pkg::HS_STOP;
            err_r   <= !ack_r;
          end
          eep_pkg::HS_RDAT:
            stage_r <= (len_r <= eep_pkg::LEN_ONE) ? eep_pkg::HS_STOP : eep_pkg::HS_RDAT;
          eep_pkg::HS_STOP:
          begin
            if ((kind_r == eep_pkg::CMD_WRITE) && !err_r)
              stage_r <= eep_pkg::HS_PSTART;
            else
            begin
              stage_r <= eep_pkg::HS_IDLE;
              done_r  <= 1'b1;
              nack_r  <= err_r;
            end
          end
          eep_pkg::HS_PSTART:
            stage_r <= eep_pkg::HS_PDEV;
          eep_pkg::HS_PDEV:
            stage_r <= eep_pkg::HS_PSTOP;
          eep_pkg::HS_PSTOP:
          begin
            // Next command only after the poll is acknowledged
            stage_r <= ack_r ? eep_pkg::HS_IDLE : eep_pkg::HS_PSTART;
            done_r  <= ack_r;
            nack_r  <= 1'b0;
          end
          default:
            stage_r <= eep_pkg::HS_IDLE;
        endcase
      end
    end
  end

  eeprom_rd_buf #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_rd_buf (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (rx_r),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  assign link.scl          = scl_r;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe  = oe_r;
  assign cmd_ready_out     = is_idle;
  assign done_out          = done_r;
  assign nack_out          = nack_r;
endmodule
`default_nettype wire

// ==== eeprom_chk.sv ====
// Protocol checker for the two-wire EEPROM link
`timescale 1ns/100ps
`default_nettype none
module eeprom_chk #(parameter int WR_CYCLES = 50) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Link and status
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  int busy_cnt_r;
  // Busy length is counted here, too long to unroll
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= busy_out ? busy_cnt_r + 1 : 0;
  // Open-drain ends only ever pull low
  chk_dev_pull_low: assert property (dev_sda_oe |-> !dev_sda_out) else $error("dev drives high");
  chk_host_pull_low: assert property (host_sda_oe |-> !host_sda_out) else $error("host drives high");
  // Device keeps off the line while writing
  chk_busy_silent: assert property (busy_out && $past(busy_out) |-> !dev_sda_oe) else $error("busy dev drove");
  chk_busy_length: assert property ($fell(busy_out) |-> busy_cnt_r >= WR_CYCLES - 1 && busy_cnt_r <= WR_CYCLES + 1)
    else $error("busy length");
  // Device moves sda only with scl low, so it never fakes a start or stop
  chk_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl) else $error("dev moved, scl high");
  chk_start_free: assert property ($fell(sda) && scl && $past(scl) |-> !dev_sda_oe) else $error("dev at start");
  chk_stop_release: assert property ($rose(sda) && scl && $past(scl) |=> !dev_sda_oe [*4]) else $error("dev at stop");
  chk_scl_high: assert property ($rose(scl) |-> scl [*8]) else $error("short scl high");
  cover property ($fell(busy_out));
  cover property ($rose(scl) && dev_sda_oe);
  cover property ($fell(sda) && scl);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Testbench joining the EEPROM master and device over one link
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module testbench;
  // Long enough that the first poll after a write is refused
  localparam int    WR = 5000;
  logic             clk_in = 1'b0, arst_n_in = 1'b0, wp = 1'b0, cmd_valid = 1'b0, cmd_cs = 1'b0, rd_ready = 1'b0;
  logic             cmd_ready, rd_valid, done, nack, busy;
  eep_pkg::cmd_type cmd_kind = eep_pkg::CMD_WRITE;
  logic [9:0]       cmd_addr = 10'h000;
  logic [7:0]       cmd_data = 8'h00, cmd_len = 8'h01, rd_data;
  int               num_errors = 0, checked = 0, busy_rises = 0;
  eeprom_link_if link ();
  eeprom_dev #(.WR_CYCLES(WR)) eeprom_dev_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link.dev),
    .chip_select_address_bit_in(1'b0), .write_protect_in(wp), .busy_out(busy));
  eeprom_host eeprom_host_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link.host), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_kind_in(cmd_kind), .cmd_cs_in(cmd_cs), .cmd_addr_in(cmd_addr),
    .cmd_data_in(cmd_data), .cmd_len_in(cmd_len), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready),
    .rd_data_out(rd_data), .done_out(done), .nack_out(nack));
  eeprom_chk #(.WR_CYCLES(WR)) eeprom_chk_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .scl(link.scl),
    .sda(link.sda), .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe), .busy_out(busy));
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  // Internal write cycles started
  always @(posedge busy)
    busy_rises++;
  task automatic tally_and_finish();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One command, then a bounded wait for done; ready is high while idle
  task automatic issue(input eep_pkg::cmd_type k, input logic [9:0] a, input logic [7:0] d, n, input logic cs, nk);
    int i;
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_cs <= cs;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_len <= n;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    for (i = 0; done !== 1'b1; i++)
    begin
      @(negedge clk_in);
      if (i > 25000)
      begin
        num_errors++;
        tally_and_finish();
      end
    end
    `CHK(nack, nk)
    `CHK(cmd_ready, 1'b1)
  endtask
  // Pop one buffered byte, comparing it when known
  task automatic take(input logic [7:0] e, input logic cmp);
    `CHK(rd_valid, 1'b1)
    if (cmp)
      `CHK(rd_data, e)
    @(posedge clk_in);
    rd_ready <= 1'b1;
    @(posedge clk_in);
    rd_ready <= 1'b0;
    @(negedge clk_in);
  endtask
  // Bytes at top and bottom; each write starts one timed cycle
  task automatic t_write();
    issue(eep_pkg::CMD_WRITE, 10'h3FF, 8'h5A, 8'h01, 1'b0, 1'b0);
    `CHK(eeprom_dev_inst.addr_r, 10'h3F0)
    issue(eep_pkg::CMD_WRITE, 10'h000, 8'hC3, 8'h01, 1'b0, 1'b0);
    `CHK(busy_rises, 2)
    $display("write test done");
  endtask
  // Protected write is acked, yet no cycle starts and the array keeps its byte
  task automatic t_protect();
    @(posedge clk_in);
    wp <= 1'b1;
    issue(eep_pkg::CMD_WRITE, 10'h000, 8'h11, 8'h01, 1'b0, 1'b0);
    `CHK(busy_rises, 2)
    @(posedge clk_in);
    wp <= 1'b0;
    $display("protect test done");
  endtask
  // Random read at the top wraps the counter; a current read then starts at zero
  task automatic t_reads();
    issue(eep_pkg::CMD_RAND_READ, 10'h3FF, 8'h00, 8'h01, 1'b0, 1'b0);
    take(8'h5A, 1'b1);
    issue(eep_pkg::CMD_CUR_READ, 10'h000, 8'h00, 8'h02, 1'b0, 1'b0);
    take(8'hC3, 1'b1);
    take(8'h00, 1'b0);
    `CHK(rd_valid, 1'b0)
    $display("read test done");
  endtask
  // Wrong select bit in the address byte is refused
  task automatic t_nack();
    issue(eep_pkg::CMD_CUR_READ, 10'h000, 8'h00, 8'h01, 1'b1, 1'b1);
    `CHK(rd_valid, 1'b0)
    $display("select test done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_write();
    t_protect();
    t_reads();
    t_nack();
    tally_and_finish();
  end
endmodule
`default_nettype wire
